// file: core/pmcc_top.sv
// Compensation datapath, output FIFO and AXI4-Lite register slave
`timescale 1ns/1ps
module pmcc_fifo #(
  parameter int W = 112,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = DEPTH[PW:0];
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] cnt_q;
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic push;
  logic pop;
  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module pmcc_top #(
  parameter int DW = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [pmcc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmcc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [DW-1:0] in_v_r,
  input wire logic signed [DW-1:0] in_v_s,
  input wire logic signed [DW-1:0] in_v_t,
  input wire logic signed [DW-1:0] in_vint_r,
  input wire logic signed [DW-1:0] in_vint_s,
  input wire logic signed [DW-1:0] in_vint_t,
  input wire logic signed [DW-1:0] in_i_r,
  input wire logic signed [DW-1:0] in_i_s,
  input wire logic signed [DW-1:0] in_i_t,
  input wire logic signed [DW-1:0] in_i_n,
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [DW-1:0] out_v_r,
  output logic signed [DW-1:0] out_v_s,
  output logic signed [DW-1:0] out_v_t,
  output logic signed [DW-1:0] out_i_r,
  output logic signed [DW-1:0] out_i_s,
  output logic signed [DW-1:0] out_i_t,
  output logic signed [DW-1:0] out_i_n,
  output logic phc_tick
);
  import pmcc_pkg::*;
  localparam int FW = 7 * DW;
  localparam int PW = DW + 8;
  localparam int MW = DW + 12;

  logic [31:0] ctrl_q;
  logic [31:0] fine_q;
  logic [31:0] mutual_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] div_cnt_q;
  logic [2:0] div_top;
  logic pm;
  logic current_sensor_type;
  logic [1:0] shared_coarse_phase_comp;
  logic [1:0] cpc_ext;
  logic [8:0] byte_a;
  logic [7:0] byte_b;
  logic [SYS_W-1:0] topo;
  logic mutual_en;
  logic single_phase;
  logic signed [7:0] k_phase [3];
  logic signed [9:0] alpha;
  logic signed [9:0] beta;
  logic signed [9:0] gamma;
  logic signed [DW-1:0] v_in [3];
  logic signed [DW-1:0] vint_in [3];
  logic signed [DW-1:0] v_cmp [3];
  logic signed [DW-1:0] i_cmp [4];
  logic signed [MW-1:0] corr_r;
  logic signed [MW-1:0] corr_s;
  logic signed [MW-1:0] corr_t;
  logic signed [MW-1:0] corr_n;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic [FW-1:0] fifo_out_data;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [7:0] phase_coef(input logic [FINE_W-1:0] fine, input logic [1:0] coarse,
                                                   input logic [1:0] ext, input logic extended);
    logic signed [7:0] sum;
    sum = extended ? $signed({1'b0, ext, coarse[0], fine}) : $signed({3'b000, coarse[0], fine});
    if (!coarse[1]) begin
      return -sum;
    end else if (extended) begin
      return K_LONG_TOP - sum;
    end
    return K_SHORT_TOP - $signed({4'h0, fine});
  endfunction

  function automatic logic signed [MW-1:0] mprod(input logic signed [9:0] c, input logic signed [DW-1:0] x);
    logic signed [DW+9:0] p;
    p = c * x;
    return MW'(p);
  endfunction

  function automatic logic signed [DW-1:0] msub(input logic signed [DW-1:0] x, input logic signed [MW-1:0] c);
    logic signed [MW-1:0] s;
    s = c >>> MUT_SHIFT;
    return x - DW'(s);
  endfunction

  assign pm = ctrl_q[CTRL_PM];
  assign current_sensor_type = ctrl_q[CTRL_TCS];
  assign shared_coarse_phase_comp = ctrl_q[CTRL_CPC_LSB +: 2];
  assign topo = ctrl_q[CTRL_SYS_LSB +: SYS_W];
  assign byte_a = mutual_q[8:0];
  assign byte_b = mutual_q[MUT_B_LSB +: 8];
  assign cpc_ext = byte_a[1:0];

  // Compensation tick from the crystal clock
  always_comb begin
    if (pm) begin
      div_top = ctrl_q[CTRL_CRYSTAL_DIVIDER_SELECT] ? DIV_4 : DIV_2;
    end else begin
      div_top = ctrl_q[CTRL_HSA] ? DIV_4 : DIV_8;
    end
  end
  assign phc_tick = div_cnt_q == 3'h0;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_cnt_q <= 3'h0;
    end else if (phc_tick || div_cnt_q > div_top) begin
      div_cnt_q <= div_top;
    end else begin
      div_cnt_q <= div_cnt_q - 3'h1;
    end
  end

  // Coefficients follow the configuration combinationally
  assign mutual_en = !current_sensor_type && !pm;
  assign single_phase = topo >= SYS_SINGLE_MIN;
  always_comb begin
    if (!mutual_en) begin
      alpha = 10'sh0;
      beta = 10'sh0;
      gamma = 10'sh0;
    end else if (single_phase) begin
      alpha = byte_a[8] ? -$signed({2'b00, byte_a[7:0]}) : $signed({2'b00, byte_a[7:0]});
      beta = byte_a[8] ? -$signed({2'b00, byte_b}) : $signed({2'b00, byte_b});
      gamma = 10'sh0;
    end else begin
      alpha = byte_a[8] ? -$signed({4'h0, byte_a[5:0]}) : $signed({4'h0, byte_a[5:0]});
      beta = byte_a[7] ? -$signed({5'h00, byte_b[7:3]}) : $signed({5'h00, byte_b[7:3]});
      gamma = byte_a[6] ? -$signed({7'h00, byte_b[2:0]}) : $signed({7'h00, byte_b[2:0]});
    end
  end

  assign v_in[0] = in_v_r;
  assign v_in[1] = in_v_s;
  assign v_in[2] = in_v_t;
  assign vint_in[0] = in_vint_r;
  assign vint_in[1] = in_vint_s;
  assign vint_in[2] = in_vint_t;

  // Vector phase compensation per phase
  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scaled;
    assign k_phase[p] = phase_coef(fine_q[FINE_W*p +: FINE_W], shared_coarse_phase_comp, cpc_ext, pm || current_sensor_type);
    assign prod = k_phase[p] * vint_in[p];
    assign scaled = prod >>> PHC_SHIFT;
    assign v_cmp[p] = v_in[p] - DW'(scaled);
  end

  // Mutual current correction
  always_comb begin
    if (single_phase) begin
      corr_r = '0;
      corr_s = mprod(beta, in_i_t);
      corr_t = mprod(alpha, in_i_s);
      corr_n = '0;
    end else begin
      corr_r = mprod(alpha, in_i_s) + mprod(beta, in_i_t) + mprod(gamma, in_i_n);
      corr_s = mprod(alpha, in_i_r) + mprod(alpha, in_i_t) + mprod(beta, in_i_n);
      corr_t = mprod(alpha, in_i_n) + mprod(alpha, in_i_s) + mprod(beta, in_i_r);
      corr_n = mprod(alpha, in_i_t) + mprod(beta, in_i_s) + mprod(gamma, in_i_r);
    end
  end
  assign i_cmp[0] = msub(in_i_r, corr_r);
  assign i_cmp[1] = msub(in_i_s, corr_s);
  assign i_cmp[2] = msub(in_i_t, corr_t);
  assign i_cmp[3] = msub(in_i_n, corr_n);

  // Voltages and currents enter the FIFO as one word so they keep equal latency
  assign fifo_in_data = {i_cmp[3], i_cmp[2], i_cmp[1], i_cmp[0], v_cmp[2], v_cmp[1], v_cmp[0]};
  assign in_ready = fifo_in_ready && phc_tick;

  pmcc_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(in_valid && phc_tick),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out_data)
  );
  assign out_v_r = fifo_out_data[0 +: DW];
  assign out_v_s = fifo_out_data[DW +: DW];
  assign out_v_t = fifo_out_data[2*DW +: DW];
  assign out_i_r = fifo_out_data[3*DW +: DW];
  assign out_i_s = fifo_out_data[4*DW +: DW];
  assign out_i_t = fifo_out_data[5*DW +: DW];
  assign out_i_n = fifo_out_data[6*DW +: DW];

  // AXI4-Lite write channel
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        if ({awaddr_q[AXI_AW-1:2], 2'b00} == OFF_CTRL || {awaddr_q[AXI_AW-1:2], 2'b00} == OFF_FINE ||
            {awaddr_q[AXI_AW-1:2], 2'b00} == OFF_MUTUAL) begin
          bresp_q <= RESP_OKAY;
        end else begin
          bresp_q <= RESP_SLVERR;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_q <= REG_RESET;
      fine_q <= REG_RESET;
      mutual_q <= REG_RESET;
    end else if (aw_have_q && w_have_q) begin
      if ({awaddr_q[AXI_AW-1:2], 2'b00} == OFF_CTRL) begin
        ctrl_q <= apply_strb(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
      end else if ({awaddr_q[AXI_AW-1:2], 2'b00} == OFF_FINE) begin
        fine_q <= apply_strb(fine_q, wdata_q, wstrb_q) & FINE_MASK;
      end else if ({awaddr_q[AXI_AW-1:2], 2'b00} == OFF_MUTUAL) begin
        mutual_q <= apply_strb(mutual_q, wdata_q, wstrb_q) & MUTUAL_MASK;
      end
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == OFF_CTRL) begin
        rdata_q <= ctrl_q;
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == OFF_FINE) begin
        rdata_q <= fine_q;
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == OFF_MUTUAL) begin
        rdata_q <= mutual_q;
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == OFF_KSTAT) begin
        rdata_q <= {5'h00, div_top, k_phase[2], k_phase[1], k_phase[0]};
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == OFF_CSTAT) begin
        rdata_q <= {mutual_en, single_phase, gamma, beta, alpha};
      end else begin
        rdata_q <= 32'h0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// file: core/pmcc_pkg.sv
// Constants, register map and field layout for the phase and mutual current compensation stage
// Behaviour
// - Voltage and current paths share one latency, adding no phase shift of their own.
// - Each phase has its own 4-bit fine phase compensation field.
// - Voltage minus phase coefficient times integrated voltage, before the decimation filter.
// - Short coefficient: top coarse bit 0 gives -(16*bit0+fine), else 16-fine.
// - Precision or sensor bit adds extension: -(32*ext+16*bit0+fine), or 64 minus it.
// - The 2-bit coarse extension is taken from mutual byte A.
// - Compensation tick divides crystal clock by 8/4 normally, 2/4 in precision mode.
// - Mutual correction only when the current sensor type bit is clear.
// - Mutual bytes act as coefficients only with precision mode clear, decoded by topology.
// - Single-phase: alpha=A[7:0], beta=B[7:0], signed by A[8], over 8192.
// - Single-phase: S minus beta*T, T minus alpha*S.
// - Three-phase: alpha A[5:0]/A8, beta B[7:3]/A7, gamma B[2:0]/A6, over 8192.
// - Three-phase: symmetric 4x4 matrix subtracts coupled currents from R, S, T, N.
package pmcc_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FINE = 8'h04;
  localparam logic [7:0] OFF_MUTUAL = 8'h08;
  localparam logic [7:0] OFF_KSTAT = 8'h0c;
  localparam logic [7:0] OFF_CSTAT = 8'h10;
  localparam logic [31:0] CTRL_MASK = 32'h0000_037f;
  localparam logic [31:0] FINE_MASK = 32'h0000_0fff;
  localparam logic [31:0] MUTUAL_MASK = 32'h00ff_01ff;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int CTRL_PM = 0;
  localparam int CTRL_TCS = 1;
  localparam int CTRL_HSA = 2;
  localparam int CTRL_CRYSTAL_DIVIDER_SELECT = 3;
  localparam int CTRL_SYS_LSB = 4;
  localparam int SYS_W = 3;
  localparam int CTRL_CPC_LSB = 8;
  localparam int FINE_W = 4;
  localparam int MUT_B_LSB = 16;
  localparam logic [SYS_W-1:0] SYS_SINGLE_MIN = 3'h4;
  localparam logic [2:0] DIV_8 = 3'h7;
  localparam logic [2:0] DIV_4 = 3'h3;
  localparam logic [2:0] DIV_2 = 3'h1;
  localparam logic signed [7:0] K_SHORT_TOP = 8'sh10;
  localparam logic signed [7:0] K_LONG_TOP = 8'sh40;
  localparam int MUT_SHIFT = 13;
  localparam int PHC_SHIFT = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verif/pmcc_monitor.sv
// Port checker for the compensation top
`timescale 1ns/1ps
module pmcc_monitor #(
  parameter int DW = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic signed [DW-1:0] out_i_r,
  input wire logic phc_tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence push_s;
    in_valid && in_ready;
  endsequence
  sequence stall_s;
    out_valid && !out_ready;
  endsequence
  a_ready_on_tick: assert property (in_ready |-> phc_tick) else $error("ready off tick");
  a_full_shows: assert property (phc_tick && !in_ready |-> out_valid) else $error("refused while empty");
  a_tick_gap: assert property (phc_tick |=> !phc_tick) else $error("tick too close");
  a_tick_period: assert property (phc_tick |-> ##[2:8] phc_tick) else $error("tick late");
  a_push_shows: assert property (push_s |=> out_valid) else $error("sample lost");
  a_out_hold: assert property (stall_s |=> out_valid && $stable(out_i_r)) else $error("out moved");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  a_resp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
endmodule
bind pmcc_top pmcc_monitor #(.DW(DW)) pmcc_monitor_inst (.core_clk(core_clk), .nrst(nrst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_i_r(out_i_r), .phc_tick(phc_tick));

// file: verif/pmcc_src.sv
// Upstream sample source model
`timescale 1ns/1ps
module pmcc_src (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [159:0] smp,
  input wire logic in_ready,
  output logic in_valid,
  output logic [159:0] dat
);
  always @(posedge core_clk) begin
    if (!nrst) begin
      in_valid <= 1'b0;
      dat <= 160'h0;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      dat <= ~dat;
    end else if (go && !in_valid) begin
      in_valid <= 1'b1;
      dat <= smp;
    end
  end
endmodule

// file: verif/pmcc_top_tb.sv
// Testbench for the compensation top
`timescale 1ns/1ps
module pmcc_top_tb;
  import pmcc_pkg::*;
  localparam logic [159:0] SMP = 160'h03e8_f830_0bb8_0fa0_ec78_0258_1b58_fce0_0384_fc18;
  logic core_clk, nrst, awv, wv, brdy, arv, rrdy, go, ordy, awr, wr_r, bv, arr, rv, iv, ir, ov, tick;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr, r;
  logic [159:0] sd;
  logic [111:0] ob;
  logic [95:0] rows [7];
  logic [3:0] tc [6];
  int tp [6];
  int error_cnt = 0, samples_checked = 0, cyc = 0, pops = 0, n, p0;
  pmcc_top pmcc_top_inst (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .in_valid(iv), .in_ready(ir), .in_v_r(sd[159:144]), .in_v_s(sd[143:128]), .in_v_t(sd[127:112]),
    .in_vint_r(sd[111:96]), .in_vint_s(sd[95:80]), .in_vint_t(sd[79:64]), .in_i_r(sd[63:48]),
    .in_i_s(sd[47:32]), .in_i_t(sd[31:16]), .in_i_n(sd[15:0]), .out_valid(ov), .out_ready(ordy),
    .out_v_r(ob[111:96]), .out_v_s(ob[95:80]), .out_v_t(ob[79:64]), .out_i_r(ob[63:48]),
    .out_i_s(ob[47:32]), .out_i_t(ob[31:16]), .out_i_n(ob[15:0]), .phc_tick(tick));
  pmcc_src pmcc_src_inst (.core_clk(core_clk), .nrst(nrst), .go(go), .smp(SMP), .in_ready(ir),
    .in_valid(iv), .dat(sd));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [111:0] s, input logic [111:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    logic pa, pw, ta, tw;
    @(posedge core_clk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    brdy <= 1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(negedge core_clk);
      ta = awr;
      tw = wr_r;
      @(posedge core_clk);
      if (pa && ta) begin
        awv <= 0;
        pa = 0;
      end
      if (pw && tw) begin
        wv <= 0;
        pw = 0;
      end
    end
    do @(negedge core_clk); while (!bv);
    q = br;
    @(posedge core_clk);
    brdy <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge core_clk);
    ara <= a;
    arv <= 1;
    rrdy <= 1;
    do @(negedge core_clk); while (!arr);
    @(posedge core_clk);
    arv <= 0;
    do @(negedge core_clk); while (!rv);
    v = rdat;
    q = rr;
    @(posedge core_clk);
    rrdy <= 0;
  endtask
  task automatic per(output int c);
    do @(negedge core_clk); while (!tick);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (!tick);
  endtask
  task automatic push;
    @(posedge core_clk);
    go <= 1;
    @(posedge core_clk);
    go <= 0;
    do @(negedge core_clk); while (iv);
  endtask
  function automatic logic [111:0] mdl(input logic [31:0] c, input logic [31:0] f, input logic [31:0] m);
    int v[10], o[10], k, a, b, g, x;
    for (int j = 0; j < 10; j++) v[j] = int'($signed(SMP[159-16*j -: 16]));
    x = (c[0] | c[1]) ? 1 : 0;
    for (int p = 0; p < 3; p++) begin
      k = 32 * x * int'(m[1:0]) + 16 * int'(c[8]) + int'(f[4*p +: 4]);
      k = c[9] ? (x ? 64 - k : 16 - int'(f[4*p +: 4])) : -k;
      v[p] = v[p] - ((k * v[p+3]) >>> 12);
    end
    o = v;
    if (x == 0 && c[6:4] >= 3'h4) begin
      a = m[8] ? -int'(m[7:0]) : int'(m[7:0]);
      b = m[8] ? -int'(m[23:16]) : int'(m[23:16]);
      v[7] = o[7] - ((b * o[8]) >>> 13);
      v[8] = o[8] - ((a * o[7]) >>> 13);
    end else if (x == 0) begin
      a = m[8] ? -int'(m[5:0]) : int'(m[5:0]);
      b = m[7] ? -int'(m[23:19]) : int'(m[23:19]);
      g = m[6] ? -int'(m[18:16]) : int'(m[18:16]);
      v[6] = o[6] - ((a * o[7] + b * o[8] + g * o[9]) >>> 13);
      v[7] = o[7] - ((a * o[6] + a * o[8] + b * o[9]) >>> 13);
      v[8] = o[8] - ((a * o[9] + a * o[7] + b * o[6]) >>> 13);
      v[9] = o[9] - ((a * o[8] + b * o[7] + g * o[6]) >>> 13);
    end
    return {16'(v[0]), 16'(v[1]), 16'(v[2]), 16'(v[6]), 16'(v[7]), 16'(v[8]), 16'(v[9])};
  endfunction
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ov && ordy) pops <= pops + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude;
    end
  end
  initial begin
    {nrst, awv, wv, brdy, arv, rrdy, go} = 0;
    {awa, ara, wd} = 0;
    ordy = 1;
    tc = '{4'h0, 4'h4, 4'h1, 4'h9, 4'h5, 4'h8};
    tp = '{8, 4, 2, 4, 2, 8};
    rows = '{96'h00000000_00000a53_00ab016a, 96'h00000120_00000fff_00f700c5, 96'h00000240_00000123_008101ff,
      96'h00000370_00000456_00330042, 96'h00000222_00000789_00aa0002, 96'h00000101_00000cde_00550003,
      96'h00000302_00000f0f_00000001};
    repeat (9) @(posedge core_clk);
    @(negedge core_clk);
    chk("rst", {bv, rv, ov}, 3'h0);
    chk("rst_tick", tick, 1'b1);
    @(posedge core_clk);
    nrst <= 1;
    rd(OFF_CTRL, d, r);
    chk("ctrl_rst", d, REG_RESET);
    wr(OFF_CTRL, 32'hffff_ffff, r);
    rd(OFF_CTRL, d, r);
    chk("ctrl_mask", d, CTRL_MASK);
    rd(OFF_KSTAT, d, r);
    chk("kstat", d, 32'h0330_3030);
    rd(OFF_CSTAT, d, r);
    chk("cstat", d, 32'h4000_0000);
    wr(8'h14, 32'h1, r);
    chk("wr_unmap", r, RESP_SLVERR);
    rd(8'h14, d, r);
    chk("rd_unmap", {r, d}, {RESP_SLVERR, 32'h0});
    $display("test regs done");
    foreach (tc[j]) begin
      wr(OFF_CTRL, {28'h0, tc[j]}, r);
      per(n);
      per(n);
      chk("tick", n, tp[j]);
    end
    $display("test ticks done");
    foreach (rows[j]) begin
      wr(OFF_CTRL, rows[j][95:64], r);
      wr(OFF_FINE, rows[j][63:32], r);
      wr(OFF_MUTUAL, rows[j][31:0], r);
      push;
      chk("row", ob, mdl(rows[j][95:64], rows[j][63:32], rows[j][31:0]));
    end
    $display("test rows done");
    wr(OFF_CTRL, 32'h4, r);
    ordy <= 0;
    p0 = pops;
    repeat (4) push;
    @(posedge core_clk);
    go <= 1;
    @(posedge core_clk);
    go <= 0;
    repeat (20) @(negedge core_clk);
    chk("full", {iv, ir, ov}, 3'h5);
    @(posedge core_clk);
    ordy <= 1;
    repeat (40) @(negedge core_clk);
    chk("drain", pops - p0, 5);
    chk("empty", {iv, ov}, 2'h0);
    $display("test fifo done");
    conclude;
  end
endmodule
